// *** hdl/drt_timer.sv ***
/*
  Top of the dual reload timer: I/O register decode, free-running divide
  by twenty prescaler, shared control/status register, zero flags with
  their read-sequence clear, interrupt requests and the waveform output
  that shares a pin with an address line.
  Assumes a processor I/O bus with one-cycle read/write strobes that are
  synchronous to MCLK_I; read data is presented the cycle after the strobe.
*/
`timescale 1ns/1ns
module drt_timer (
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  input wire logic [7:0] IO_ADDR_I,
  input wire logic [7:0] IO_WDATA_I,
  input wire logic IO_WR_I,
  input wire logic IO_RD_I,
  input wire logic SHARED_ADDR_I,
  output logic [7:0] IO_RDATA_O,
  output logic IRQ_CH0_O,
  output logic IRQ_CH1_O,
  output logic SHARED_PIN_O
);

  // ************************************************************
  // State
  // ************************************************************
  logic [4:0] presc_q; // Prescaler phase, 0..19
  logic [5:0] ctl_q; // Irq enables, output select, run bits
  logic [5:0] ctl_d;
  logic [1:0] flag_q; // Zero flags, index = channel
  logic [1:0] flag_d;
  logic [1:0] arm_q; // Control read seen, clear pending
  logic [1:0] arm_d;
  logic [1:0] irq_q; // Registered interrupt requests
  logic par_q; // Channel-1 timeout parity
  logic par_d;
  logic wave_q; // Waveform level
  logic wave_d;
  logic pin_q; // Shared pin driver
  logic [7:0] rdata_q; // Read data latch

  // ************************************************************
  // Prescaler
  // ************************************************************
  // Ignores the bus entirely so timing never drifts with access
  wire tick = CE_I && (presc_q == drt_pkg::PRESC_LAST);

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      presc_q <= 5'h00;
    end else if (CE_I) begin
      presc_q <= tick ? 5'h00 : presc_q + 5'h01;
    end
  end

  // ************************************************************
  // Decode
  // ************************************************************
  wire wr = CE_I & IO_WR_I;
  wire rd = CE_I & IO_RD_I;
  wire ctl_wr = wr && (IO_ADDR_I == drt_pkg::OFS_CTL);
  wire ctl_rd = rd && (IO_ADDR_I == drt_pkg::OFS_CTL);
  wire [1:0] run = ctl_q[drt_pkg::BIT_RUN0 +: 2];
  wire [1:0] ien = ctl_q[drt_pkg::BIT_IEN0 +: 2];
  wire [1:0] wsel = ctl_q[drt_pkg::BIT_WSEL_LO +: 2];
  wire [7:0] ctl_val = {flag_q[1], flag_q[0], ctl_q}; // Flags on top

  logic [1:0] zero; // Zero pulse per channel
  logic [1:0] cnt_rd; // Either counter byte read per channel
  logic [1:0] ch_hit; // Address falls in channel window
  logic [7:0] ch_rd [2]; // Read value per channel

  // ************************************************************
  // Channels
  // ************************************************************
  for (genvar i = 0; i < 2; i++) begin : g_ch
    localparam logic [7:0] CL = (i == 0) ? drt_pkg::OFS_CNT_LO_CH0 : drt_pkg::OFS_CNT_LO_CH1;
    localparam logic [7:0] CH = (i == 0) ? drt_pkg::OFS_CNT_HI_CH0 : drt_pkg::OFS_CNT_HI_CH1;
    localparam logic [7:0] RL = (i == 0) ? drt_pkg::OFS_RLD_LO_CH0 : drt_pkg::OFS_RLD_LO_CH1;
    localparam logic [7:0] RH = (i == 0) ? drt_pkg::OFS_RLD_HI_CH0 : drt_pkg::OFS_RLD_HI_CH1;
    wire a_cl = (IO_ADDR_I == CL);
    wire a_ch = (IO_ADDR_I == CH);
    wire a_rl = (IO_ADDR_I == RL);
    wire a_rh = (IO_ADDR_I == RH);
    drt_pkg::drt_chreq_t req;
    logic [15:0] cnt;
    logic [15:0] rld;
    logic [7:0] hi_rd;

    assign req.wr_cnt_lo = wr & a_cl;
    assign req.wr_cnt_hi = wr & a_ch;
    assign req.wr_rld_lo = wr & a_rl;
    assign req.wr_rld_hi = wr & a_rh;
    assign req.rd_cnt_lo = rd & a_cl;
    assign req.wdata = IO_WDATA_I;
    assign cnt_rd[i] = rd & (a_cl | a_ch);
    assign ch_hit[i] = a_cl | a_ch | a_rl | a_rh;
    assign ch_rd[i] = a_cl ? cnt[7:0] : a_ch ? hi_rd : a_rl ? rld[7:0] : a_rh ? rld[15:8] : 8'h00;

    drt_channel u_ch (
      .clk_i(MCLK_I),
      .rst_n_i(RSTN_I),
      .ce_i(CE_I),
      .tick_i(tick),
      .run_i(run[i]),
      .req_i(req),
      .count_o(cnt),
      .reload_o(rld),
      .hi_rd_o(hi_rd),
      .zero_o(zero[i])
    );

    // Flag sets win over a clear in the same cycle
    // Clear needs control read first, then this channel's counter read
    assign flag_d[i] = zero[i] | (flag_q[i] & ~(arm_q[i] & cnt_rd[i]));
    assign arm_d[i] = ctl_rd | (arm_q[i] & ~cnt_rd[i]);

    a_flag_set: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      zero[i] |=> flag_q[i])
      else $error("Zero flag not set at timeout");

    a_flag_keep: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      (flag_q[i] && !arm_q[i]) |=> flag_q[i])
      else $error("Zero flag cleared without control read");

    a_irq_level: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
      CE_I |=> (irq_q[i] == ($past(flag_q[i]) && $past(ien[i]))))
      else $error("Interrupt request does not follow flag and enable");
  end

  // ************************************************************
  // Control, flags and interrupts
  // ************************************************************
  // Software owns the low six bits; flags are read-only
  assign ctl_d = ctl_wr ? IO_WDATA_I[5:0] : ctl_q;

  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctl_q <= drt_pkg::CTL_RST; // Stops counting, irqs off, address pin
      flag_q <= 2'h0;
      arm_q <= 2'h0;
      irq_q <= 2'h0;
    end else if (CE_I) begin
      ctl_q <= ctl_d;
      flag_q <= flag_d;
      arm_q <= arm_d;
      irq_q <= flag_q & ien; // Request held while both set
    end
  end

  // ************************************************************
  // Waveform output
  // ************************************************************
  // Parity tracks every channel-1 timeout even while the pin is an address,
  // so a later select starts high after even counts and low after odd ones
  assign par_d = par_q ^ zero[1];

  always_comb begin
    wave_d = wave_q;
    if (wsel == drt_pkg::WAVE_ADDR) begin
      wave_d = ~par_d; // Preloads start level for the next select
    end else if (zero[1]) begin
      case (wsel)
        drt_pkg::WAVE_TOGGLE: wave_d = ~wave_q; // Square wave, no software
        drt_pkg::WAVE_LOW: wave_d = 1'b0;
        drt_pkg::WAVE_HIGH: wave_d = 1'b1;
        default: wave_d = wave_q;
      endcase
    end
  end

  // Pin follows the address line unless a wave function is selected;
  // registering the address costs one cycle but keeps the output a flop
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      par_q <= 1'b0;
      wave_q <= 1'b1;
      pin_q <= 1'b0; // Address function after reset
    end else if (CE_I) begin
      par_q <= par_d;
      wave_q <= wave_d;
      pin_q <= (wsel == drt_pkg::WAVE_ADDR) ? SHARED_ADDR_I : wave_d;
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  wire [7:0] rd_val = ctl_rd ? ctl_val : ch_hit[0] ? ch_rd[0] : ch_hit[1] ? ch_rd[1] :
    drt_pkg::UNMAPPED_RD;

  // Latched on the read strobe, stands until the next read
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rdata_q <= 8'h00;
    end else if (rd) begin
      rdata_q <= rd_val;
    end
  end

  assign IO_RDATA_O = rdata_q;
  assign IRQ_CH0_O = irq_q[0];
  assign IRQ_CH1_O = irq_q[1];
  assign SHARED_PIN_O = pin_q;

  // ************************************************************
  // Checks
  // ************************************************************
  a_presc_wrap: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    tick |=> (presc_q == 5'h00))
    else $error("Prescaler did not wrap after tick");

  a_pin_addr: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    (CE_I && wsel == drt_pkg::WAVE_ADDR) |=> (SHARED_PIN_O == $past(SHARED_ADDR_I)))
    else $error("Pin not following address line");

  a_wave_toggle: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    (wsel == drt_pkg::WAVE_TOGGLE && zero[1]) |=> (wave_q != $past(wave_q)))
    else $error("Toggle mode did not invert");

  a_wave_start: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
    (CE_I && wsel == drt_pkg::WAVE_ADDR) |=> (wave_q == ~par_q))
    else $error("Start level does not match timeout parity");

endmodule

// *** hdl/drt_pkg.sv ***
/*
  Shared constants and types of the dual reload timer: I/O byte offsets,
  control-bit positions, reset values, prescale count and the request
  carrier that the top hands to each channel.
  Assumes an 8-bit processor I/O bus with single-cycle read and write strobes.
*/
// Operation
// - Counters decrement every 20 clocks, shared tick.
// - At zero, counter reloads from its reload register.
// - Reset presets counters/reloads, stops, pin to address.
// - Low-byte read latches high byte for next read.
// - Run bit enables counting; clear means direct access.
// - Reaching zero sets channel zero flag, bits 7/6.
// - Flag clears after control read then counter read.
// - Interrupt request while flag and enable both set.
// - Output select: address, toggle, low, high.
// - Toggle mode inverts pin on each channel-1 zero.
// - Never timed out: pin starts high when selected.
// - After timeouts: even count high, odd count low.
package drt_pkg;

  // ************************************************************
  // Register map (byte addresses on the I/O bus)
  // ************************************************************
  localparam logic [7:0] OFS_CNT_LO_CH0 = 8'h0c; // Counter low byte, channel 0
  localparam logic [7:0] OFS_CNT_HI_CH0 = 8'h0d; // Counter high byte, channel 0
  localparam logic [7:0] OFS_RLD_LO_CH0 = 8'h0e; // Reload low byte, channel 0
  localparam logic [7:0] OFS_RLD_HI_CH0 = 8'h0f; // Reload high byte, channel 0
  localparam logic [7:0] OFS_CTL = 8'h10; // Shared control/status
  localparam logic [7:0] OFS_CNT_LO_CH1 = 8'h14;
  localparam logic [7:0] OFS_CNT_HI_CH1 = 8'h15;
  localparam logic [7:0] OFS_RLD_LO_CH1 = 8'h16;
  localparam logic [7:0] OFS_RLD_HI_CH1 = 8'h17;
  localparam logic [7:0] UNMAPPED_RD = 8'h00; // Answer for unmapped reads

  // ************************************************************
  // Control/status field positions
  // ************************************************************
  localparam int BIT_FLAG0 = 6; // Zero flag ch0, ch1 sits one above
  localparam int BIT_IEN0 = 4; // Irq enable ch0, ch1 one above
  localparam int BIT_WSEL_LO = 2; // Output select, two bits
  localparam int BIT_RUN0 = 0; // Count run ch0, ch1 one above

  // ************************************************************
  // Reset values and timing
  // ************************************************************
  localparam logic [15:0] CNT_RST = 16'hffff; // Counter after reset
  localparam logic [15:0] RLD_RST = 16'hffff; // Reload after reset
  localparam logic [5:0] CTL_RST = 6'h00; // Writable control bits after reset
  localparam int PRESC_DIV = 20; // System clocks per count tick
  localparam logic [4:0] PRESC_LAST = 5'(PRESC_DIV - 1);

  // Output select encodings
  typedef enum logic [1:0] {
    WAVE_ADDR = 2'h0,
    WAVE_TOGGLE = 2'h1,
    WAVE_LOW = 2'h2,
    WAVE_HIGH = 2'h3
  } drt_wave_t;

  // Per-channel bus request carrier
  typedef struct packed {
    logic wr_cnt_lo; // Counter low byte write
    logic wr_cnt_hi; // Counter high byte write
    logic wr_rld_lo; // Reload low byte write
    logic wr_rld_hi; // Reload high byte write
    logic rd_cnt_lo; // Counter low byte read
    logic [7:0] wdata; // Write data
  } drt_chreq_t;

endpackage

// *** hdl/drt_channel.sv ***
/*
  One reload timer channel: 16-bit down counter, reload register and the
  high-byte holding latch for coherent byte-pair reads.
  Assumes the top supplies a single-cycle count tick and decoded strobes.
*/
`timescale 1ns/1ns
module drt_channel (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic run_i,
  input wire drt_pkg::drt_chreq_t req_i,
  output logic [15:0] count_o,
  output logic [15:0] reload_o,
  output logic [7:0] hi_rd_o,
  output logic zero_o
);

  logic [15:0] count_q; // Down counter
  logic [15:0] count_d;
  logic [15:0] reload_q; // Reload value
  logic [15:0] reload_d;
  logic [7:0] hold_q; // High byte captured on low-byte read

  // ************************************************************
  // Decrement and reload
  // ************************************************************
  wire dec = tick_i & run_i; // Counting only while run bit set
  wire [15:0] dec_val = count_q - 16'h0001;
  wire hit = dec & (dec_val == 16'h0000); // Reaching zero on this tick

  // Next count: direct writes first, then reload on zero, else decrement
  always_comb begin
    count_d = count_q;
    if (req_i.wr_cnt_lo) begin
      count_d = {count_q[15:8], req_i.wdata};
    end else if (req_i.wr_cnt_hi) begin
      count_d = {req_i.wdata, count_q[7:0]};
    end else if (hit) begin
      count_d = reload_q; // Reload on the same tick as the flag
    end else if (dec) begin
      count_d = dec_val; // One step per shared tick
    end
  end

  // Reload bytes written independently; software keeps them coherent
  always_comb begin
    reload_d = reload_q;
    if (req_i.wr_rld_lo) begin
      reload_d[7:0] = req_i.wdata;
    end
    if (req_i.wr_rld_hi) begin
      reload_d[15:8] = req_i.wdata;
    end
  end

  // Counter and reload flops, frozen while clock enable is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= drt_pkg::CNT_RST;
      reload_q <= drt_pkg::RLD_RST;
    end else if (ce_i) begin
      count_q <= count_d;
      reload_q <= reload_d;
    end
  end

  // Holding latch: low-byte read captures the high byte
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_q <= 8'hff;
    end else if (ce_i && req_i.rd_cnt_lo) begin
      hold_q <= count_q[15:8];
    end
  end

  // Running: held byte; stopped: live byte so any order works
  assign hi_rd_o = run_i ? hold_q : count_q[15:8];
  assign count_o = count_q;
  assign reload_o = reload_q;
  assign zero_o = ce_i & hit;

  // ************************************************************
  // Checks
  // ************************************************************
  wire no_wr = !(req_i.wr_cnt_lo || req_i.wr_cnt_hi);

  a_reload_on_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && hit && no_wr) |=> (count_q == $past(reload_q)))
    else $error("Counter did not reload at zero");

  a_hold_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && req_i.rd_cnt_lo && run_i) ##1 (run_i && !(ce_i && req_i.rd_cnt_lo))
      |-> (hi_rd_o == $past(count_q[15:8])))
    else $error("High byte read not from holding latch");

  a_stopped_still: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!run_i && no_wr) |=> (count_q == $past(count_q)))
    else $error("Stopped counter changed");

  a_step_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ce_i && dec && !hit && no_wr) |=> (count_q == $past(count_q) - 16'h0001))
    else $error("Counter did not step by one");

endmodule

// *** tb/drt_timer_tb.sv ***
/*
  Self-checking bench for the dual reload timer top: reset values, counting
  rate, reload, flag clear sequence, interrupt masking, byte-pair latch and
  the waveform pin in every select setting.
  Assumes the single-cycle I/O strobes and one-cycle read latency of the top.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end

module drt_timer_tb;
  // ************************************************************
  // Stimulus signals, all given a value at time zero
  // ************************************************************
  logic clk = 1'b0; // 10 MHz system clock
  logic rst_n = 1'b0; // Active low reset
  logic ce = 1'b1; // Clock enable, on except while t_freeze holds it low
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic sh_addr = 1'b0; // Address line routed to the pin in mode 00
  logic [7:0] rdata;
  logic irq0;
  logic irq1;
  logic pin;
  int err_count = 0;
  int check_count = 0;
  localparam logic [7:0] CTL = drt_pkg::OFS_CTL;

  // Half period of 50 ns
  always begin
    #50 clk = ~clk;
  end

  drt_timer uut (
    .MCLK_I(clk), .RSTN_I(rst_n), .CE_I(ce), .IO_ADDR_I(addr), .IO_WDATA_I(wdata),
    .IO_WR_I(wr_s), .IO_RD_I(rd_s), .SHARED_ADDR_I(sh_addr), .IO_RDATA_O(rdata),
    .IRQ_CH0_O(irq0), .IRQ_CH1_O(irq1), .SHARED_PIN_O(pin)
  );

  // ************************************************************
  // Bus helpers: each access spans two edges, taken at the second
  // ************************************************************
  // Returns just after the last edge, so outputs are read once settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #5;
    wr_s = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #5;
    wr_s = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #5;
    rd_s = 1'b1;
    addr = a;
    @(posedge clk);
    #5;
    rd_s = 1'b0;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask

  // Edges from a taken run write to a taken stop write span 20*k, minus
  // two edges per access made in between; any 20-edge span holds one tick
  task automatic run_for(input int k, input int accesses);
    cyc(20 * k - 2 - 2 * accesses);
  endtask

  task automatic do_reset;
    rst_n = 1'b0;
    cyc(8);
    rst_n = 1'b1;
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Reset values of every register, unmapped read and outputs
  task automatic t_reset;
    logic [7:0] m[8] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h14, 8'h15, 8'h16, 8'h17};
    rd_chk(CTL, 8'h00);
    foreach (m[i]) begin
      rd_chk(m[i], 8'hff);
    end
    rd_chk(8'h20, drt_pkg::UNMAPPED_RD);
    `CHK({irq1, irq0}, 2'b00)
    `CHK(pin, 1'b0)
  endtask

  // Three ticks with bus traffic inside the window, then frozen count
  task automatic t_count;
    logic [7:0] d;
    wr(8'h0c, 8'h05); // Counter written while stopped
    wr(8'h0d, 8'h00);
    wr(CTL, 8'h01);
    rd(CTL, d);
    wr(8'h0e, 8'h09); // Reload rewritten long before the next zero
    run_for(3, 2);
    wr(CTL, 8'h00);
    cyc(60); // Stopped counter must not move here
    rd_chk(8'h0c, 8'h02);
    rd_chk(8'h0d, 8'h00);
  endtask

  // Clock enable low freezes prescaler, counter and the bus; only the
  // sixty enabled edges up to the stop write may hold count ticks
  task automatic t_freeze;
    wr(8'h0c, 8'h10);
    wr(8'h0d, 8'h00);
    wr(CTL, 8'h01);
    ce = 1'b0;
    wr(8'h0c, 8'hee); // Must be ignored while frozen
    cyc(96);
    ce = 1'b1;
    cyc(58);
    wr(CTL, 8'h00);
    rd_chk(8'h0c, 8'h0d);
    rd_chk(8'h0d, 8'h00);
  endtask

  // High byte held by the low read while the count crosses 0100
  task automatic t_latch;
    logic [7:0] d;
    wr(8'h0c, 8'h02);
    wr(8'h0d, 8'h01);
    wr(CTL, 8'h01);
    rd(8'h0c, d); // Low byte first, then high byte
    cyc(60);
    rd_chk(8'h0d, 8'h01);
    wr(CTL, 8'h00);
    rd_chk(8'h0d, 8'h00);
  endtask

  // Waveform pin: start level on select, level after one timeout
  task automatic t_wave;
    logic [1:0] sel[5] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h2};
    logic st[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic af[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    wr(8'h14, 8'h01);
    wr(8'h15, 8'h00);
    wr(8'h16, 8'h01);
    wr(8'h17, 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(CTL, 8'h00);
      wr(CTL, {4'h0, sel[i], 2'b00});
      cyc(3);
      `CHK(pin, st[i])
      wr(CTL, {4'h0, sel[i], 2'b10});
      run_for(1, 0);
      wr(CTL, {4'h0, sel[i], 2'b00});
      cyc(3);
      `CHK(pin, af[i])
    end
    // Back to the address function
    wr(CTL, 8'h00);
    sh_addr = 1'b1;
    cyc(3);
    `CHK(pin, 1'b1)
    sh_addr = 1'b0;
    cyc(3);
    `CHK(pin, 1'b0)
  endtask

  // Reload, flag, interrupt masking and the two-step flag clear
  task automatic t_flag(input int ch);
    logic [7:0] b;
    logic [7:0] d;
    logic [1:0] m;
    b = (ch == 1) ? 8'h14 : 8'h0c;
    m = 2'(1 << ch);
    wr(b, 8'h02);
    wr(b + 8'h01, 8'h00);
    wr(b + 8'h02, 8'h04); // Reload bytes written while stopped
    wr(b + 8'h03, 8'h00);
    rd(b, d); // Drops this channel's clear left armed by earlier control reads
    wr(CTL, {2'h0, m, 2'h0, m});
    run_for(3, 0);
    wr(CTL, {2'h0, m, 4'h0});
    cyc(3);
    `CHK({irq1, irq0}, m)
    rd_chk(b, 8'h03);
    rd_chk(CTL, {m, m, 4'h0});
    wr(CTL, 8'h00);
    cyc(3);
    `CHK({irq1, irq0}, 2'b00)
    wr(CTL, {2'h0, m, 4'h0});
    cyc(3);
    `CHK({irq1, irq0}, m)
    rd_chk(b + 8'h01, 8'h00);
    cyc(3);
    `CHK({irq1, irq0}, 2'b00)
    rd_chk(CTL, {2'h0, m, 4'h0});
  endtask

  // ************************************************************
  // Verdict, watchdog and main sequence
  // ************************************************************
  task automatic final_report;
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Whole run needs about 800 cycles; allow far more before giving up
  initial begin
    #(100 * 20000);
    err_count++;
    final_report();
  end

  initial begin
    do_reset();
    t_reset();
    t_count();
    t_freeze();
    t_latch();
    t_wave();
    t_flag(1);
    t_flag(0);
    do_reset(); // Second reset with counters, reloads and the channel-0 irq enable dirtied
    t_reset();
    final_report();
  end
endmodule
